//--- core/eic_pkg.sv
package eic_pkg;

   // ======================================================================
   // register map (byte addresses on the register bus)
   // ======================================================================
   localparam logic [15:0] ADDR_SYSTEM_CONTROL   = 16'hfff2;
   localparam logic [15:0] ADDR_SENSE_CONTROL    = 16'hfff4;
   localparam logic [15:0] ADDR_REQUEST_ENABLE   = 16'hfff5;
   localparam logic [15:0] ADDR_REQUEST_FLAGS    = 16'hfff6;
   localparam logic [15:0] ADDR_PRIORITY_LEVEL_A = 16'hfff8;
   localparam logic [15:0] ADDR_PRIORITY_LEVEL_B = 16'hfff9;

   // ======================================================================
   // reset values and field positions
   // ======================================================================
   localparam logic [7:0] SYSCTL_RESET      = 8'h0b;
   localparam logic [7:0] SENSE_RESET       = 8'h00;
   localparam logic [7:0] ENABLE_RESET      = 8'h00;
   localparam logic [7:0] FLAGS_RESET       = 8'h00;
   localparam logic [7:0] PRIO_RESET        = 8'h00;
   localparam int         SYSCTL_UE_BIT     = 3;
   localparam int         SYSCTL_NONMASKABLE_EDGE_SELECT_BIT  = 2;
   localparam logic [7:0] SYSCTL_FIXED_ONES = 8'h02;
   localparam logic [7:0] FLAGS_USED_MASK   = 8'h1f;
   localparam int         NUM_EXT_REQ       = 5;

   // ======================================================================
   // vector numbers
   // ======================================================================
   localparam logic [5:0] VEC_RESET = 6'h00;
   localparam logic [5:0] VEC_NMI   = 6'h07;
   localparam logic [5:0] VEC_TRAP0 = 6'h08;
   localparam logic [5:0] VEC_IRQ0  = 6'h0c;

   // ======================================================================
   // timing: least reset-low time while running (system clocks) and at power-up (ms)
   // ======================================================================
   localparam int         RESET_MIN_CYCLES = 10;
   localparam int         POWERUP_RESET_MS = 20;

   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      EIC_RESET   = 2'b00,
      EIC_VECTOR  = 2'b01,
      EIC_FIRST   = 2'b10,
      EIC_RUN     = 2'b11
   } eic_state_e;

   // accepted exception handed to the cpu core
   typedef struct packed {
      logic       valid;
      logic [5:0] vector;
      logic [1:0] mask_set;   // [1]=ui bit, [0]=i bit set by entry
      logic       push_ctx;   // push pc and ccr first
   } eic_take_s;

endpackage

//--- core/eic_top.sv
`timescale 1ns/1ps

// Overview of operation
// - reset pin low halts all processing and holds the reset state.
// - reset exception handling starts on the reset pin's rising edge.
// - reset initialises core state and all registers, sets mask bit.
// - after reset, fetch start address from the reset vector.
// - watchdog overflow resets exactly like the reset pin.
// - all interrupts blocked after reset until first instruction executed.
// - non-maskable interrupt has top priority and ignores mask bits.
// - maskable requests sit in one of two levels and are arbitrated.
// - every source gets its own vector number.
// - mask bit and user bit give three masking levels.
// - trap sets mask bit; sets user bit too when user bit enable 0.
// - trap field 0 to 3 selects vectors 8 to 11.
// - word and longword accesses force the lowest address bit to 0.
// - system control bit 2 picks non-maskable edge, 0 falling.
// - system control bit 3 picks user bit role, reset value 1.
// - system control resets to 0b, including hardware standby entry.
// - each external request picks falling edge or low level sensing.
// - writing 0 clears a request flag; writing 1 does nothing.
// - priority A bit 7 sets level of external request 0.
// - priority A clears to 00 on reset and hardware standby.
// - accepting pushes pc and ccr, sets mask, then fetches vector.
// - pending request taken only after current instruction completes.
// - external requests 0 to 4 use vectors 12 to 16, nmi 7.
module eic_top (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         nrst_i,
   // pins
   input  wire logic         reset_pin_n_i,
   input  wire logic         nmi_pin_i,
   input  wire logic [4:0]   ext_req_n_i,
   input  wire logic         hw_standby_i,
   // watchdog and cpu core
   input  wire logic         watchdog_overflow_i,
   input  wire logic         insn_boundary_i,
   input  wire logic         ccr_mask_i,
   input  wire logic         ccr_user_i,
   input  wire logic         trap_i,
   input  wire logic [1:0]   trap_field_i,
   input  wire logic         take_ack_i,
   input  wire logic [23:0]  core_addr_i,
   input  wire logic         core_wide_i,
   output logic              core_reset_o,
   output logic [23:0]       core_addr_o,
   output eic_pkg::eic_take_s take_o,
   output logic              ue_o,
   // axi4-lite slave
   input  wire logic [15:0]  s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [15:0]  s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready
);

   // ======================================================================
   // pin synchronisers
   // ======================================================================
   logic [2:0] res_sync;
   logic [2:0] nmi_sync;
   logic [4:0] irq_s1, irq_s2, irq_s3;
   logic       res_lvl, nmi_lvl;
   logic [4:0] irq_lvl;

   always_ff @(posedge mclk_i) begin
      res_sync <= {res_sync[1:0], reset_pin_n_i};
      nmi_sync <= {nmi_sync[1:0], nmi_pin_i};
      irq_s1   <= ext_req_n_i;
      irq_s2   <= irq_s1;
      irq_s3   <= irq_s2;
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         res_lvl <= 1'b0;
         nmi_lvl <= 1'b1;
         irq_lvl <= 5'h1f;
      end else begin
         if (res_sync[1] == res_sync[2])
            res_lvl <= res_sync[2];
         if (nmi_sync[1] == nmi_sync[2])
            nmi_lvl <= nmi_sync[2];
         for (int i = 0; i < eic_pkg::NUM_EXT_REQ; i++) begin
            if (irq_s2[i] == irq_s3[i])
               irq_lvl[i] <= irq_s3[i];
         end
      end
   end

   // ======================================================================
   // reset sequencing
   // ======================================================================
   eic_pkg::eic_state_e state;
   logic res_lvl_q;
   logic in_reset;
   logic res_rise;

   // either pin low or a watchdog overflow puts the device into reset
   assign in_reset = !res_lvl || watchdog_overflow_i;
   assign res_rise = res_lvl && !res_lvl_q;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i)
         res_lvl_q <= 1'b0;
      else
         res_lvl_q <= res_lvl;
   end

   logic wdt_seen;
   always_ff @(posedge mclk_i) begin
      if (!nrst_i)
         wdt_seen <= 1'b0;
      else if (watchdog_overflow_i)
         wdt_seen <= 1'b1;
      else if (state == eic_pkg::EIC_VECTOR)
         wdt_seen <= 1'b0;
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || in_reset) begin
         state <= eic_pkg::EIC_RESET;
      end else begin
         unique case (state)
            eic_pkg::EIC_RESET: begin
               if (res_rise || wdt_seen)
                  state <= eic_pkg::EIC_VECTOR;
            end
            eic_pkg::EIC_VECTOR: begin
               if (take_ack_i)
                  state <= eic_pkg::EIC_FIRST;
            end
            eic_pkg::EIC_FIRST: begin
               if (insn_boundary_i)
                  state <= eic_pkg::EIC_RUN;
            end
            eic_pkg::EIC_RUN: begin
               state <= eic_pkg::EIC_RUN;
            end
         endcase
      end
   end

   logic dev_reset;
   assign dev_reset = !nrst_i || in_reset || state == eic_pkg::EIC_RESET;

   always_ff @(posedge mclk_i) begin
      core_reset_o <= dev_reset;
   end

   // ======================================================================
   // registers
   // ======================================================================
   logic [7:0] sysctl, sense, enable, flags, prio_a, prio_b;
   logic       reg_clr;
   logic       wr_go;
   logic [15:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic       aw_held, w_held;

   assign reg_clr = dev_reset || hw_standby_i;
   assign wr_go   = aw_held && w_held && !s_axi_bvalid;

   function automatic logic [7:0] wbyte(input logic [15:0] a,
                                        input logic [31:0] d);
      wbyte = d[8*a[1:0] +: 8];
   endfunction

   function automatic logic lane_on(input logic [15:0] a,
                                    input logic [3:0] s);
      lane_on = s[a[1:0]];
   endfunction

   logic wr_hit_sys, wr_hit_sense, wr_hit_en, wr_hit_flags;
   logic wr_hit_pa, wr_hit_pb;
   logic wr_lane;
   logic [7:0] wr_byte;
   assign wr_byte      = wbyte(aw_addr, w_data);
   assign wr_lane      = wr_go && lane_on(aw_addr, w_strb);
   assign wr_hit_sys   = wr_lane && aw_addr == eic_pkg::ADDR_SYSTEM_CONTROL;
   assign wr_hit_sense = wr_lane && aw_addr == eic_pkg::ADDR_SENSE_CONTROL;
   assign wr_hit_en    = wr_lane && aw_addr == eic_pkg::ADDR_REQUEST_ENABLE;
   assign wr_hit_flags = wr_lane && aw_addr == eic_pkg::ADDR_REQUEST_FLAGS;
   assign wr_hit_pa    = wr_lane && aw_addr == eic_pkg::ADDR_PRIORITY_LEVEL_A;
   assign wr_hit_pb    = wr_lane && aw_addr == eic_pkg::ADDR_PRIORITY_LEVEL_B;

   always_ff @(posedge mclk_i) begin
      if (reg_clr)
         sysctl <= eic_pkg::SYSCTL_RESET;
      else if (wr_hit_sys)
         sysctl <= wbyte(aw_addr, w_data) | eic_pkg::SYSCTL_FIXED_ONES;
   end

   always_ff @(posedge mclk_i) begin
      if (reg_clr) begin
         sense  <= eic_pkg::SENSE_RESET;
         enable <= eic_pkg::ENABLE_RESET;
         prio_a <= eic_pkg::PRIO_RESET;
         prio_b <= eic_pkg::PRIO_RESET;
      end else begin
         if (wr_hit_sense)
            sense <= wbyte(aw_addr, w_data);
         if (wr_hit_en)
            enable <= wbyte(aw_addr, w_data);
         if (wr_hit_pa)
            prio_a <= wbyte(aw_addr, w_data);
         if (wr_hit_pb)
            prio_b <= wbyte(aw_addr, w_data);
      end
   end

   // ======================================================================
   // external request detection and flags
   // ======================================================================
   logic [4:0] irq_lvl_q;
   logic [4:0] flag_set, flag_clr, irq_taken;
   logic       nmi_lvl_q, nmi_edge, nmi_pend;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         irq_lvl_q <= 5'h1f;
         nmi_lvl_q <= 1'b1;
      end else begin
         irq_lvl_q <= irq_lvl;
         nmi_lvl_q <= nmi_lvl;
      end
   end

   always_comb begin
      for (int i = 0; i < eic_pkg::NUM_EXT_REQ; i++) begin
         // sense bit 0: low level, 1: falling edge
         flag_set[i] = sense[i] ? (irq_lvl_q[i] && !irq_lvl[i])
                                : !irq_lvl[i];
         flag_clr[i] = (wr_hit_flags && !wr_byte[i])
                     || (irq_taken[i] && (sense[i] || irq_lvl[i]));
      end
   end

   // set beats clear when both land in one cycle
   always_ff @(posedge mclk_i) begin
      if (reg_clr)
         flags <= eic_pkg::FLAGS_RESET;
      else
         flags <= {3'b000, flag_set | (flags[4:0] & ~flag_clr)};
   end

   assign nmi_edge = sysctl[eic_pkg::SYSCTL_NONMASKABLE_EDGE_SELECT_BIT]
                   ? (nmi_lvl && !nmi_lvl_q)
                   : (!nmi_lvl && nmi_lvl_q);

   // ======================================================================
   // arbitration and exception entry
   // ======================================================================
   logic [4:0] req_lvl1, req_any, prio_bits;
   logic       mask_ok_hi, mask_ok_lo, run_ok;
   logic [2:0] win;
   logic       win_ok;
   eic_pkg::eic_take_s next_take;

   // request 0,1 each own bit; 2,3 share one; 4 its own
   assign prio_bits = {prio_a[4], prio_a[5], prio_a[5], prio_a[6],
                       prio_a[7]};
   assign req_any   = flags[4:0] & enable[4:0];
   assign req_lvl1  = req_any & prio_bits;

   // three masking levels from the i and ui bits
   always_comb begin
      if (sysctl[eic_pkg::SYSCTL_UE_BIT]) begin
         mask_ok_hi = !ccr_mask_i;
         mask_ok_lo = !ccr_mask_i;
      end else begin
         // with the mask bit clear every level passes, whatever the user bit
         mask_ok_hi = !ccr_mask_i;
         mask_ok_lo = !ccr_mask_i;
      end
      if (!sysctl[eic_pkg::SYSCTL_UE_BIT] && ccr_mask_i) begin
         mask_ok_hi = !ccr_user_i;
         mask_ok_lo = 1'b0;
      end
   end

   function automatic logic [2:0] first_set(input logic [4:0] v);
      first_set = 3'h7;
      for (int i = eic_pkg::NUM_EXT_REQ - 1; i >= 0; i--) begin
         if (v[i])
            first_set = 3'(i);
      end
   endfunction

   always_comb begin
      win    = 3'h7;
      win_ok = 1'b0;
      if (|req_lvl1 && mask_ok_hi) begin
         win    = first_set(req_lvl1);
         win_ok = 1'b1;
      end else if (|(req_any & ~prio_bits) && mask_ok_lo) begin
         win    = first_set(req_any & ~prio_bits);
         win_ok = 1'b1;
      end
   end

   assign run_ok = state == eic_pkg::EIC_RUN && insn_boundary_i
                   && !take_o.valid;

   always_ff @(posedge mclk_i) begin
      if (reg_clr || in_reset)
         nmi_pend <= 1'b0;
      else if (nmi_edge)
         nmi_pend <= 1'b1;
      else if (run_ok)
         nmi_pend <= 1'b0;
   end

   always_comb begin
      next_take = take_o;
      irq_taken = 5'h00;
      if (take_o.valid && take_ack_i)
         next_take.valid = 1'b0;
      if (state == eic_pkg::EIC_RESET && (res_rise || wdt_seen)) begin
         next_take.valid    = 1'b1;
         next_take.vector   = eic_pkg::VEC_RESET;
         next_take.mask_set = 2'b01;
         next_take.push_ctx = 1'b0;
      end else if (run_ok && nmi_pend) begin
         next_take.valid    = 1'b1;
         next_take.vector   = eic_pkg::VEC_NMI;
         next_take.mask_set = {!sysctl[eic_pkg::SYSCTL_UE_BIT], 1'b1};
         next_take.push_ctx = 1'b1;
      end else if (run_ok && win_ok) begin
         next_take.valid    = 1'b1;
         next_take.vector   = eic_pkg::VEC_IRQ0 + 6'(win);
         next_take.mask_set = {!sysctl[eic_pkg::SYSCTL_UE_BIT], 1'b1};
         next_take.push_ctx = 1'b1;
         irq_taken[win]     = 1'b1;
      end else if (run_ok && trap_i) begin
         next_take.valid    = 1'b1;
         next_take.vector   = eic_pkg::VEC_TRAP0 + 6'(trap_field_i);
         next_take.mask_set = {!sysctl[eic_pkg::SYSCTL_UE_BIT], 1'b1};
         next_take.push_ctx = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || in_reset)
         take_o <= '0;
      else
         take_o <= next_take;
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i)
         core_addr_o <= 24'h000000;
      else
         core_addr_o <= core_wide_i ? {core_addr_i[23:1], 1'b0}
                                    : core_addr_i;
   end

   always_ff @(posedge mclk_i) begin
      if (reg_clr)
         ue_o <= 1'b1;
      else
         ue_o <= sysctl[eic_pkg::SYSCTL_UE_BIT];
   end

   // ======================================================================
   // axi4-lite slave
   // ======================================================================
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 16'h0000;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= eic_pkg::AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(aw_addr) ? eic_pkg::AXI_OKAY
                                             : eic_pkg::AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic reg_hit(input logic [15:0] a);
      reg_hit = a == eic_pkg::ADDR_SYSTEM_CONTROL
             || a == eic_pkg::ADDR_SENSE_CONTROL
             || a == eic_pkg::ADDR_REQUEST_ENABLE
             || a == eic_pkg::ADDR_REQUEST_FLAGS
             || a == eic_pkg::ADDR_PRIORITY_LEVEL_A
             || a == eic_pkg::ADDR_PRIORITY_LEVEL_B;
   endfunction

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      end
   end

   logic [7:0] rd_byte;
   always_comb begin
      unique case (s_axi_araddr)
         eic_pkg::ADDR_SYSTEM_CONTROL:   rd_byte = sysctl;
         eic_pkg::ADDR_SENSE_CONTROL:    rd_byte = sense;
         eic_pkg::ADDR_REQUEST_ENABLE:   rd_byte = enable;
         eic_pkg::ADDR_REQUEST_FLAGS:    rd_byte = flags;
         eic_pkg::ADDR_PRIORITY_LEVEL_A: rd_byte = prio_a;
         eic_pkg::ADDR_PRIORITY_LEVEL_B: rd_byte = prio_b;
         default:                        rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= eic_pkg::AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte} << (8 * s_axi_araddr[1:0]);
            s_axi_rresp  <= reg_hit(s_axi_araddr) ? eic_pkg::AXI_OKAY
                                                  : eic_pkg::AXI_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ======================================================================
   // checks
   // ======================================================================
   property p_reset_holds;
      @(posedge mclk_i) disable iff (!nrst_i)
      (!res_lvl) |=> core_reset_o && !take_o.valid;
   endproperty
   a_reset_holds: assert property (p_reset_holds)
      else $error("core not held in reset while pin low");

   property p_reset_vector;
      @(posedge mclk_i) disable iff (!nrst_i)
      (state == eic_pkg::EIC_RESET && res_rise && !in_reset)
         |=> take_o.valid && take_o.vector == eic_pkg::VEC_RESET
             && take_o.mask_set[0];
   endproperty
   a_reset_vector: assert property (p_reset_vector)
      else $error("reset vector not issued on release");

   property p_no_irq_first;
      @(posedge mclk_i) disable iff (!nrst_i)
      (state != eic_pkg::EIC_RUN) |=> !take_o.valid
         || take_o.vector == eic_pkg::VEC_RESET;
   endproperty
   a_no_irq_first: assert property (p_no_irq_first)
      else $error("interrupt taken before first instruction");

   property p_sysctl_init;
      @(posedge mclk_i) disable iff (!nrst_i)
      hw_standby_i |=> sysctl == eic_pkg::SYSCTL_RESET
                        && prio_a == eic_pkg::PRIO_RESET;
   endproperty
   a_sysctl_init: assert property (p_sysctl_init)
      else $error("standby did not reinitialise registers");

   property p_flag_set_wins;
      @(posedge mclk_i) disable iff (!nrst_i)
      (!reg_clr && flag_set[0]) |=> flags[0];
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins)
      else $error("request flag lost");

   property p_trap_vector;
      @(posedge mclk_i) disable iff (!nrst_i)
      (run_ok && trap_i && !nmi_pend && !win_ok && !in_reset)
         |=> take_o.vector == eic_pkg::VEC_TRAP0 + 6'($past(trap_field_i));
   endproperty
   a_trap_vector: assert property (p_trap_vector)
      else $error("trap vector wrong");

   property p_nmi_first;
      @(posedge mclk_i) disable iff (!nrst_i)
      (run_ok && nmi_pend && !in_reset && !reg_clr)
         |=> take_o.vector == eic_pkg::VEC_NMI;
   endproperty
   a_nmi_first: assert property (p_nmi_first)
      else $error("nmi not preferred");

   property p_wide_even;
      @(posedge mclk_i) disable iff (!nrst_i)
      core_wide_i |=> !core_addr_o[0];
   endproperty
   a_wide_even: assert property (p_wide_even)
      else $error("odd wide address");

endmodule

//--- verification/eic_cpu_model.sv
`timescale 1ns/1ps
// ====================
// cpu core stand-in
module eic_cpu_model (
   // clock and offer
   input  wire logic mclk_i,
   input  wire logic valid_i,
   // core answers
   output logic      boundary_o = 1'b0,
   output logic      ack_o = 1'b0
);
   // boundary only every other clock, so requests must wait for it
   always @(posedge mclk_i) boundary_o <= ~boundary_o;
   // one consume pulse per offer, never two back to back
   always @(posedge mclk_i) ack_o <= valid_i & ~ack_o;
endmodule

//--- verification/exception_interrupt_control_tb.sv
`timescale 1ns/1ps
module exception_interrupt_control_tb;
   // ====================
   // signals
   logic mclk_i = 0, nrst_i = 0, reset_pin_n_i = 0, nmi_pin_i = 1;
   logic hw_standby_i = 0, watchdog_overflow_i = 0, trap_i = 0;
   logic ccr_mask_i = 1, ccr_user_i = 0, core_wide_i = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic insn_boundary_i, take_ack_i, core_reset_o, ue_o;
   logic [4:0] ext_req_n_i = '1;
   logic [1:0] trap_field_i = 0, s_axi_bresp, s_axi_rresp, r;
   logic [23:0] core_addr_i = 0, core_addr_o;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h1d9b, rv;
   logic [3:0] s_axi_wstrb = 0;
   logic [7:0] d;
   eic_pkg::eic_take_s take_o;
   int num_errors = 0, compares = 0, i;

   eic_top dut (.*);
   eic_cpu_model cpu (.mclk_i(mclk_i), .valid_i(take_o.valid),
      .boundary_o(insn_boundary_i), .ack_o(take_ack_i));

   initial forever #25 mclk_i = ~mclk_i;

   // ====================
   // helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask

   task end_sim();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task to(input int n);
      if (n >= 99) begin
         num_errors++;
         end_sim();
      end
   endtask

   task wr(input logic [15:0] a, input logic [7:0] e);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'(e) << (8 * a[1:0]);
      s_axi_wstrb <= 4'h1 << a[1:0];
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 99 && !s_axi_bvalid; n++) begin
         @(posedge mclk_i);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 0;
      to(n);
      @(posedge mclk_i);
   endtask

   task rd(input logic [15:0] a, output logic [7:0] v, output logic [1:0] p);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 99 && !s_axi_rvalid; n++) begin
         @(posedge mclk_i);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      s_axi_rready <= 0;
      v = 8'(s_axi_rdata >> (8 * a[1:0]));
      p = s_axi_rresp;
      to(n);
      @(posedge mclk_i);
   endtask

   task rc(input logic [15:0] a, input logic [7:0] e);
      rd(a, d, r);
      chk("reg", d, e);
      chk("resp", r, 2'b00);
   endtask

   // core sets its mask on entry, so level requests cannot re-enter
   task wt(input logic [5:0] v, input logic [1:0] m, input logic p);
      int n;
      for (n = 0; n < 99 && take_o.valid !== 1'b1; n++) @(posedge mclk_i);
      to(n);
      chk("vector", take_o.vector, v);
      chk("mask", take_o.mask_set, m);
      chk("push", take_o.push_ctx, p);
      ccr_mask_i <= 1;
      trap_i <= 0;
      ext_req_n_i <= '1;
      repeat (4) @(posedge mclk_i);
   endtask

   // ====================
   // scenarios
   initial begin
      repeat (3) @(posedge mclk_i);
      nrst_i <= 1;
      repeat (12) @(posedge mclk_i);
      chk("in_reset", core_reset_o, 1);
      chk("early", take_o.valid, 0);
      reset_pin_n_i <= 1;
      wt(6'h00, 2'b01, 0);
      rc(16'hfff2, 8'h0b);
      rc(16'hfff4, 8'h00);
      rc(16'hfff5, 8'h00);
      rc(16'hfff8, 8'h00);
      rc(16'hfff9, 8'h00);
      wr(16'hfff6, 8'(xs()));
      rc(16'hfff6, 8'h00);
      rd(16'hfff0, d, r);
      chk("unmapped", r, 2'b10);
      chk("ue", ue_o, 1);
      for (i = 0; i < 8; i++) begin
         if (i % 4 == 0) wr(16'hfff2, i < 4 ? 8'h03 : 8'h0b);
         trap_field_i <= 2'(i);
         trap_i <= 1;
         wt(6'h08 + 6'(i % 4), i < 4 ? 2'b11 : 2'b01, 1);
      end
      nmi_pin_i <= 0;
      wt(6'h07, 2'b01, 1);
      wr(16'hfff2, 8'h0f);
      nmi_pin_i <= 1;
      wt(6'h07, 2'b01, 1);
      wr(16'hfff5, 8'h1f);
      wr(16'hfff4, 8'h15);
      for (i = 0; i < 5; i++) begin
         ccr_mask_i <= 0;
         ext_req_n_i[i] <= 0;
         wt(6'h0c + 6'(i), 2'b01, 1);
         wr(16'hfff6, 8'h00);
      end
      wr(16'hfff8, 8'h10);
      ccr_mask_i <= 0;
      ext_req_n_i <= 5'h0e;
      wt(6'h10, 2'b01, 1);
      ccr_mask_i <= 0;
      wt(6'h0c, 2'b01, 1);
      wr(16'hfff2, 8'h03);
      ccr_user_i <= 0;
      ext_req_n_i <= 5'h0f;
      wt(6'h10, 2'b11, 1);
      ccr_mask_i <= 0;
      ccr_user_i <= 1;
      ext_req_n_i <= 5'h1e;
      wt(6'h0c, 2'b11, 1);
      ccr_user_i <= 0;
      hw_standby_i <= 1;
      @(posedge mclk_i);
      hw_standby_i <= 0;
      rc(16'hfff8, 8'h00);
      watchdog_overflow_i <= 1;
      @(posedge mclk_i);
      watchdog_overflow_i <= 0;
      wt(6'h00, 2'b01, 0);
      rc(16'hfff5, 8'h00);
      for (i = 0; i < 8; i++) begin
         rv = xs();
         core_addr_i <= rv[23:0];
         core_wide_i <= rv[24];
         repeat (2) @(posedge mclk_i);
         chk("addr", core_addr_o, {rv[23:1], rv[0] & ~rv[24]});
      end
      end_sim();
   end
endmodule
